// [gdfm_cfg.svh]
`ifndef GDFM_CFG_SVH
`define GDFM_CFG_SVH

// Clock period and interval steps, all in nanoseconds.
`define GDFM_CLK_NS 4
`define GDFM_WARN_HALF_NS 56000
`define GDFM_DEAD_STEP_NS 40
`define GDFM_BLANK_STEP_NS 500
`define GDFM_DEGL_STEP_NS 500
`define GDFM_DRV_STEP_NS 250

// Register indices; the byte address is four times the index.
`define GDFM_IDX_WARN 4'h1
`define GDFM_IDX_OCP 4'h2
`define GDFM_IDX_SUP 4'h3
`define GDFM_IDX_SINK 4'h5
`define GDFM_IDX_SRC 4'h6
`define GDFM_IDX_TIME 4'h7
`define GDFM_IDX_CTRL 4'h9
`define GDFM_IDX_VDS 4'hC

// Field positions.
`define GDFM_FAULT_BIT 10
`define GDFM_DRV_LSB 8
`define GDFM_DEAD_LSB 4
`define GDFM_BLANK_LSB 2
`define GDFM_DEGL_LSB 0
`define GDFM_GCHK_BIT 8
`define GDFM_CLR_BIT 1
`define GDFM_THR_LSB 3
`define GDFM_OCR_LSB 0

// Reset values of the writable registers.
`define GDFM_RST_SINK 16'h0000
`define GDFM_RST_SRC 16'h0000
`define GDFM_RST_TIME 16'h0000
`define GDFM_RST_CTRL 16'h0000
`define GDFM_RST_VDS 16'h0000

`endif

// [gdfm_gate.sv]
`timescale 1ns/100ps
module gdfm_gate import gdfm_pkg::*; (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Shared timing and control.
    gdfm_gate_if.gate cfg,
    // Command and sensing.
    input wire logic cmd_i,
    input wire logic opp_off_i,
    input wire logic opp_sw_i,
    input wire logic fb_i,
    input wire logic trip_i,
    // Drive and events.
    output logic drive_o,
    output logic sw_o,
    output logic strong_pd_o,
    output logic hold_o,
    output logic vds_evt_o,
    output logic gate_err_o
);
    gdfm_gate_st_e state_r;
    gdfm_cnt_t dcnt_r, tcnt_r, bcnt_r, gcnt_r;
    logic drive_r, drv_d_r, hold_r, err_r, pd_r, evt_r;
    logic edge_w;

    assign edge_w = drive_r ^ drv_d_r;

    // Turn-on waits for the opposite gate, then a dead time; shutdown wins.
    always_ff @(posedge clk_i) begin
        if (rst_i || cfg.shutdown) begin
            state_r <= GS_OFF;
            drive_r <= 1'b0; // [R7]
            dcnt_r <= '0;
        end else begin
            case (state_r)
                GS_OFF: begin
                    if (cmd_i) begin
                        state_r <= GS_WAIT;
                    end
                end
                GS_WAIT: begin
                    if (!cmd_i) begin
                        state_r <= GS_OFF;
                    end else if (opp_off_i) begin
                        state_r <= GS_DEAD; // [R12]
                        dcnt_r <= cfg.dead_cyc - 10'd1;
                    end
                end
                GS_DEAD: begin
                    if (!cmd_i) begin
                        state_r <= GS_OFF;
                    end else if (dcnt_r == '0) begin
                        state_r <= GS_ON; // [R13]
                        drive_r <= 1'b1;
                    end else begin
                        dcnt_r <= dcnt_r - 10'd1;
                    end
                end
                GS_ON: begin
                    if (!cmd_i) begin
                        state_r <= GS_OFF;
                        drive_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= GS_OFF;
                    drive_r <= 1'b0;
                end
            endcase
        end
    end

    // Drive timer: strong current until expiry, then hold current and a level check.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_d_r <= 1'b0;
            tcnt_r <= '0;
            hold_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            drv_d_r <= drive_r;
            err_r <= 1'b0;
            if (edge_w) begin
                tcnt_r <= drive_r ? cfg.on_cyc : cfg.off_cyc;
                hold_r <= 1'b0;
            end else if (tcnt_r != '0) begin
                tcnt_r <= tcnt_r - 10'd1;
                if (tcnt_r == 10'd1) begin
                    hold_r <= 1'b1; // [R23]
                    err_r <= cfg.check_en && (fb_i != drive_r); // [R21]
                end
            end
        end
    end

    // Strong pulldown only while the opposite gate is switching on.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pd_r <= 1'b0;
        end else begin
            pd_r <= !drive_r && opp_sw_i; // [R20]
        end
    end

    // Blanking after turn-on, then a trip must persist for the deglitch time.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bcnt_r <= '0;
            gcnt_r <= '0;
            evt_r <= 1'b0;
        end else begin
            evt_r <= 1'b0;
            if (edge_w && drive_r) begin
                bcnt_r <= cfg.blank_cyc; // [R15]
            end else if (bcnt_r != '0) begin
                bcnt_r <= bcnt_r - 10'd1;
            end
            if (!drive_r || bcnt_r != '0 || !trip_i) begin
                gcnt_r <= '0;
            end else if (gcnt_r != cfg.degl_cyc) begin
                gcnt_r <= gcnt_r + 10'd1;
                evt_r <= (gcnt_r == cfg.degl_cyc - 10'd1); // [R16]
            end
        end
    end

    assign drive_o = drive_r;
    assign sw_o = drive_r && tcnt_r != '0;
    assign strong_pd_o = pd_r;
    assign hold_o = hold_r;
    assign vds_evt_o = evt_r;
    assign gate_err_o = err_r;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    handshake_wait_a: assert property (state_r == GS_WAIT && !opp_off_i |=> !drive_r) // [R12]
        else $error("gate turned on before the handshake");
    dead_min_a: assert property ($rose(drive_r) |-> $past(state_r == GS_DEAD, 10)) // [R13]
        else $error("dead time shorter than minimum");
    shut_off_a: assert property (cfg.shutdown |=> !drive_r) // [R7]
        else $error("gate still driven during shutdown");
    blank_quiet_a: assert property (bcnt_r != '0 |=> !evt_r) // [R15]
        else $error("overcurrent event during blanking");
    hold_after_a: assert property (tcnt_r == 10'd1 && !edge_w |=> hold_r) // [R23]
        else $error("hold current not selected at timer expiry");
endmodule

// [gdfm_gate_if.sv]
`timescale 1ns/100ps
interface gdfm_gate_if;
    import gdfm_pkg::*;
    gdfm_cnt_t dead_cyc;
    gdfm_cnt_t blank_cyc;
    gdfm_cnt_t degl_cyc;
    gdfm_cnt_t on_cyc;
    gdfm_cnt_t off_cyc;
    logic shutdown;
    logic check_en;
    modport ctl(output dead_cyc, blank_cyc, degl_cyc, on_cyc, off_cyc, shutdown, check_en);
    modport gate(input dead_cyc, blank_cyc, degl_cyc, on_cyc, off_cyc, shutdown, check_en);
endinterface

// [gdfm_mcu.sv]
`timescale 1ns/100ps
module gdfm_mcu (
    // Clock.
    input wire logic clk_i,
    // Open-drain pin drive from the device.
    input wire logic oe_n_i,
    input wire logic dat_i,
    // Resolved pin and last low run.
    output logic pin_o,
    output int low_len_o
);
    int run_r;
    // External pull-up holds the line high whenever the device lets go.
    assign pin_o = oe_n_i ? 1'b1 : dat_i;
    // Length of the most recent low phase, as the controller would time it.
    always_ff @(posedge clk_i) begin
        run_r <= (pin_o === 1'b0) ? run_r + 1 : 0;
        if (pin_o === 1'b0) begin
            low_len_o <= run_r + 1;
        end
    end
endmodule

// [gdfm_pkg.sv]
package gdfm_pkg;
`include "gdfm_cfg.svh"

    typedef logic [9:0] gdfm_cnt_t;

    typedef enum logic [1:0] {
        GS_OFF = 2'b00,
        GS_WAIT = 2'b01,
        GS_DEAD = 2'b10,
        GS_ON = 2'b11
    } gdfm_gate_st_e;

    typedef enum logic [2:0] {
        OCR_LATCH = 3'b000,
        OCR_REPORT = 3'b001,
        OCR_OFF = 3'b010
    } gdfm_ocr_e;

    // Converts a least time to whole clock cycles, rounding up, never below one.
    function automatic gdfm_cnt_t gdfm_ns2cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + `GDFM_CLK_NS - 1) / `GDFM_CLK_NS;
        if (c == 0) begin
            c = 1;
        end
        return gdfm_cnt_t'(c);
    endfunction
endpackage

// [gdfm_pulse.sv]
`timescale 1ns/100ps
module gdfm_pulse import gdfm_pkg::*; #(
    parameter int unsigned HALF_CYC = 14000
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Pattern request and low phase.
    input wire logic run_i,
    output logic low_o
);
    localparam logic [15:0] LAST = 16'(HALF_CYC - 1);
    logic [15:0] cnt_r;
    logic hi_ph_r;

    // The pattern always restarts with a full low half when reporting begins.
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_r <= 16'h0000;
            hi_ph_r <= 1'b0;
        end else if (cnt_r == LAST) begin
            cnt_r <= 16'h0000;
            hi_ph_r <= !hi_ph_r; // [R2]
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    assign low_o = run_i && !hi_ph_r;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    half_toggle_a: assert property (run_i && cnt_r == LAST ##1 run_i |-> hi_ph_r != $past(hi_ph_r)) // [R2]
        else $error("warning pattern half did not end on time");
    half_hold_a: assert property (run_i && cnt_r != LAST ##1 run_i |-> $stable(hi_ph_r)) // [R25]
        else $error("warning pattern changed phase early");
endmodule

// [gdfm_top.sv]
// Summary of operation
// [R1] Warnings only report, never change gate drive.
// [R2] Warning pulses fault pin 56 us low/high.
// [R3] Status read stops pulsing; status follows condition.
// [R4] Acknowledged warning repulses only after recurrence.
// [R5] Fault: shutdown, pin low, summary bit set.
// [R6] Fault takes priority over an active warning.
// [R7] Any fault pulls all gate outputs low.
// [R8] Controller removes cause, then clears or pulses enable.
// [R9] Clear bit self-clears once faults and pin release.
// [R10] Temperature flags real-time, no fault pin action.
// [R11] Watchdog and regulator faults also on power-good.
// [R12] Turn-on waits for opposite gate handshake.
// [R13] Programmable dead time, at least 40 ns.
// [R14] Overcurrent threshold register, changeable while running.
// [R15] Blank comparators after each commanded turn-on.
// [R16] Trip must persist deglitch time to count.
// [R17] Response select; latched mode shuts down, identifies FET.
// [R18] Report-only mode reports, gates keep running.
// [R19] Disabled mode neither acts nor reports.
// [R20] Strong pulldown while opposite switches, then weak.
// [R21] Drive timer expiry compares gate against command.
// [R22] Source pin over 2 V latches shutdown fault.
// [R23] Late gate flags fault, else hold current; hold current is selected at timer expiry even for a late gate.
// [R24] Watchdog/regulator faults pull gates low, latch pins.
// [R25] Intervals counted on the logic clock.
// [R26] Clearing with cause present relatches at once.
`timescale 1ns/100ps
`include "gdfm_cfg.svh"
module gdfm_top import gdfm_pkg::*; #(
    parameter int unsigned WARN_HALF_CYC = `GDFM_WARN_HALF_NS / `GDFM_CLK_NS
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Gate commands and sensing; bits 2:0 high side, 5:3 low side.
    input wire logic gate_en_i,
    input wire logic [5:0] gate_cmd_i,
    input wire logic [5:0] gs_off_i,
    input wire logic [5:0] gate_fb_i,
    input wire logic [5:0] vds_trip_i,
    input wire logic [2:0] low_side_source_pin_i,
    // Monitored conditions.
    input wire logic [3:0] warn_cond_i,
    input wire logic [3:0] temperature_flags_i,
    input wire logic [3:0] supply_fault_i,
    input wire logic watchdog_fault_i,
    input wire logic regulator_undervoltage_i,
    // Gate outputs.
    output logic [5:0] gate_drive_o,
    output logic [5:0] strong_pd_o,
    output logic [5:0] hold_o,
    output logic [4:0] drain_source_threshold_o,
    // Open-drain fault pin and power-good.
    input wire logic fault_report_n_i,
    output logic fault_report_n_o,
    output logic fault_report_oe_n_o,
    output logic power_good_out_o
);
    gdfm_gate_if gif();

    logic [15:0] sink_r, src_r, time_r, ctrl_r, vds_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [3:0] warn_d_r, warn_pend_r;
    logic [5:0] vds_lat_r, vds_rep_r, gmis_r;
    logic [3:0] sup_r;
    logic [2:0] sns_r;
    logic wd_r, ruv_r, en_d_r, clr_r, oe_n_r, pg_r;
    logic [5:0] drive_w, sw_w, evt_w, err_w;
    logic req_w, wr_w, rd_w, clr_p_w, any_fault_w, warn_act_w, pulse_low_w, pin_seen_w;
    logic [3:0] idx_w;
    gdfm_ocr_e ocr_w;

    // Merges a write into a 16-bit register by byte enables.
    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    assign idx_w = wb_adr_i[5:2];
    assign req_w = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr_w = req_w && wb_we_i;
    assign rd_w = req_w && !wb_we_i;
    assign ocr_w = gdfm_ocr_e'(vds_r[`GDFM_OCR_LSB +: 3]);
    assign pin_seen_w = fault_report_n_i;

    // Single-cycle answer; every access is acknowledged, unmapped ones read zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req_w;
        end
    end

    // Writable configuration registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sink_r <= `GDFM_RST_SINK;
            src_r <= `GDFM_RST_SRC;
            time_r <= `GDFM_RST_TIME;
            vds_r <= `GDFM_RST_VDS;
        end else if (wr_w) begin
            case (idx_w)
                `GDFM_IDX_SINK: sink_r <= wmerge(sink_r, wb_dat_i, wb_sel_i);
                `GDFM_IDX_SRC: src_r <= wmerge(src_r, wb_dat_i, wb_sel_i);
                `GDFM_IDX_TIME: time_r <= wmerge(time_r, wb_dat_i, wb_sel_i);
                `GDFM_IDX_VDS: vds_r <= wmerge(vds_r, wb_dat_i, wb_sel_i); // [R14] [R17]
                default: begin
                end
            endcase
        end
    end

    // Control register; the clear bit drops itself once faults are gone and the pin is free.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `GDFM_RST_CTRL;
        end else if (wr_w && idx_w == `GDFM_IDX_CTRL) begin
            ctrl_r <= wmerge(ctrl_r, wb_dat_i, wb_sel_i);
        end else if (ctrl_r[`GDFM_CLR_BIT] && !any_fault_w && oe_n_r) begin
            ctrl_r[`GDFM_CLR_BIT] <= 1'b0; // [R9]
        end
    end

    // Read data is captured in the request cycle so that it stands with ack.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (rd_w) begin
            dat_r <= 32'h0000_0000;
            case (idx_w)
                `GDFM_IDX_WARN: begin
                    dat_r[`GDFM_FAULT_BIT] <= any_fault_w; // [R5]
                    dat_r[8] <= temperature_flags_i[3]; // [R10]
                    dat_r[7:4] <= warn_cond_i; // [R3]
                    dat_r[3:1] <= {temperature_flags_i[0], temperature_flags_i[1], temperature_flags_i[2]};
                end
                `GDFM_IDX_OCP: dat_r[8:0] <= {vds_lat_r | vds_rep_r, sns_r}; // [R17] [R18]
                `GDFM_IDX_SUP: dat_r[11:0] <= {ruv_r, wd_r, gmis_r, sup_r};
                `GDFM_IDX_SINK: dat_r[15:0] <= sink_r;
                `GDFM_IDX_SRC: dat_r[15:0] <= src_r;
                `GDFM_IDX_TIME: dat_r[15:0] <= time_r;
                `GDFM_IDX_CTRL: dat_r[15:0] <= ctrl_r;
                `GDFM_IDX_VDS: dat_r[15:0] <= vds_r;
                default: dat_r <= 32'h0000_0000;
            endcase
        end
    end

    // Timing counts from the select fields; updates take effect at once.
    assign gif.dead_cyc = gdfm_ns2cyc(`GDFM_DEAD_STEP_NS * (32'(time_r[`GDFM_DEAD_LSB +: 3]) + 1)); // [R13] [R25]
    assign gif.blank_cyc = gdfm_ns2cyc(`GDFM_BLANK_STEP_NS * (32'(time_r[`GDFM_BLANK_LSB +: 2]) + 1)); // [R15]
    assign gif.degl_cyc = gdfm_ns2cyc(`GDFM_DEGL_STEP_NS * (32'(time_r[`GDFM_DEGL_LSB +: 2]) + 1)); // [R16]
    assign gif.on_cyc = gdfm_ns2cyc(`GDFM_DRV_STEP_NS * (32'(src_r[`GDFM_DRV_LSB +: 2]) + 1));
    assign gif.off_cyc = gdfm_ns2cyc(`GDFM_DRV_STEP_NS * (32'(sink_r[`GDFM_DRV_LSB +: 2]) + 1));
    assign gif.check_en = !ctrl_r[`GDFM_GCHK_BIT]; // [R21]
    assign gif.shutdown = any_fault_w || !gate_en_i; // [R5] [R7]

    // One gate sequencer per output; the opposite gate is three places away.
    for (genvar g = 0; g < 6; g++) begin : g_gate
        gdfm_gate u_gate (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .cfg(gif.gate),
            .cmd_i(gate_cmd_i[g]),
            .opp_off_i(gs_off_i[(g + 3) % 6]),
            .opp_sw_i(sw_w[(g + 3) % 6]),
            .fb_i(gate_fb_i[g]),
            .trip_i(vds_trip_i[g]),
            .drive_o(drive_w[g]),
            .sw_o(sw_w[g]),
            .strong_pd_o(strong_pd_o[g]),
            .hold_o(hold_o[g]),
            .vds_evt_o(evt_w[g]),
            .gate_err_o(err_w[g])
        );
    end

    // Clear pulse from the control bit or from a rising gate enable.
    assign clr_p_w = ctrl_r[`GDFM_CLR_BIT] || (gate_en_i && !en_d_r); // [R8]

    // Latched faults; a cause present during the clear sets the latch again.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_d_r <= 1'b1; // Matches an idle-high enable, so leaving reset is not taken as a clear pulse.
            sup_r <= 4'h0;
            sns_r <= 3'h0;
            wd_r <= 1'b0;
            ruv_r <= 1'b0;
            gmis_r <= 6'h00;
            vds_lat_r <= 6'h00;
        end else begin
            en_d_r <= gate_en_i;
            sup_r <= (clr_p_w ? 4'h0 : sup_r) | supply_fault_i; // [R26]
            sns_r <= (clr_p_w ? 3'h0 : sns_r) | low_side_source_pin_i; // [R22]
            wd_r <= (!clr_p_w && wd_r) || watchdog_fault_i; // [R24]
            ruv_r <= (!clr_p_w && ruv_r) || regulator_undervoltage_i; // [R24]
            gmis_r <= (clr_p_w ? 6'h00 : gmis_r) | err_w; // [R21] [R23]
            if (ocr_w != OCR_REPORT && ocr_w != OCR_OFF) begin
                vds_lat_r <= (clr_p_w ? 6'h00 : vds_lat_r) | evt_w; // [R17]
            end else begin
                vds_lat_r <= clr_p_w ? 6'h00 : vds_lat_r;
            end
        end
    end

    assign any_fault_w = |{sup_r, sns_r, wd_r, ruv_r, gmis_r, vds_lat_r};

    // Warnings report once per occurrence; a status read acknowledges them.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            warn_d_r <= 4'h0;
            warn_pend_r <= 4'h0;
            vds_rep_r <= 6'h00;
        end else begin
            warn_d_r <= warn_cond_i;
            warn_pend_r <= (rd_w && idx_w == `GDFM_IDX_WARN ? 4'h0 : warn_pend_r)
                | (warn_cond_i & ~warn_d_r); // [R3] [R4]
            vds_rep_r <= (rd_w && idx_w == `GDFM_IDX_OCP ? 6'h00 : vds_rep_r)
                | (ocr_w == OCR_REPORT ? evt_w : 6'h00); // [R18] [R19]
        end
    end

    assign warn_act_w = (|warn_pend_r) || (|vds_rep_r);

    gdfm_pulse #(
        .HALF_CYC(WARN_HALF_CYC)
    ) u_pulse (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(warn_act_w),
        .low_o(pulse_low_w)
    );

    // Fault pin: a fault holds it low, otherwise a warning pulses it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_n_r <= 1'b1;
            pg_r <= 1'b1;
        end else begin
            oe_n_r <= !(any_fault_w || pulse_low_w); // [R2] [R5] [R6] [R10]
            pg_r <= !(wd_r || ruv_r); // [R11] [R24]
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign gate_drive_o = drive_w;
    assign drain_source_threshold_o = vds_r[`GDFM_THR_LSB +: 5]; // [R14]
    assign fault_report_n_o = 1'b0;
    assign fault_report_oe_n_o = oe_n_r;
    assign power_good_out_o = pg_r;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence warn_read_s;
        rd_w && idx_w == `GDFM_IDX_WARN && warn_cond_i == warn_d_r;
    endsequence
    sequence fault_seen_s;
        any_fault_w ##1 any_fault_w;
    endsequence

    warn_nostop_a: assert property (warn_act_w && !any_fault_w && gate_en_i |=> !gif.shutdown || any_fault_w) // [R1]
        else $error("warning shut the gate driver down");
    read_ack_a: assert property (warn_read_s |=> warn_pend_r == 4'h0) // [R3]
        else $error("status read did not stop warning report");
    no_repulse_a: assert property (warn_pend_r[0] == 1'b0 && warn_cond_i[0] && warn_d_r[0] |=> !warn_pend_r[0]) // [R4]
        else $error("warning reported again without recurrence");
    fault_pin_a: assert property (fault_seen_s |=> !oe_n_r) // [R5]
        else $error("fault pin not held low");
    fault_prio_a: assert property (warn_act_w && any_fault_w |=> !oe_n_r [*1] ##0 gif.shutdown) // [R6]
        else $error("warning won over a fault");
    clr_self_a: assert property (ctrl_r[`GDFM_CLR_BIT] && !any_fault_w && oe_n_r && !wr_w |=> !ctrl_r[`GDFM_CLR_BIT]) // [R9]
        else $error("clear bit did not return to zero");
    quiet_pin_a: assert property (!any_fault_w && !warn_act_w |=> oe_n_r) // [R10]
        else $error("fault pin low without a report");
    pg_fault_a: assert property (watchdog_fault_i |=> ##1 !pg_r) // [R11]
        else $error("power-good not dropped on watchdog fault");
    relatch_a: assert property (clr_p_w && watchdog_fault_i |=> wd_r) // [R26]
        else $error("fault lost while cause present");
    disabled_a: assert property (ocr_w == OCR_OFF && vds_rep_r == 6'h00 && vds_lat_r == 6'h00 |=> vds_rep_r == 6'h00) // [R19]
        else $error("disabled overcurrent was reported");
endmodule

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
    import gdfm_pkg::*;
    localparam int HALF = 20;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, gen = 1, fo, oe_n, pg, ack, wd = 0, uv = 0;
    logic [5:0] adr = 0, cmd = 0, gsoff = 6'h3f, fb = 0, trip = 0, gd, spd, hold;
    logic [3:0] wc = 0, tf = 0, sf = 0;
    logic [2:0] slp = 0;
    logic [4:0] thr;
    logic [31:0] wdat = 0, rdat, rd;
    logic pin;
    int low_len, error_cnt = 0, samples_checked = 0, k;
    gdfm_top #(.WARN_HALF_CYC(HALF)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .gate_en_i(gen), .gate_cmd_i(cmd), .gs_off_i(gsoff), .gate_fb_i(fb), .vds_trip_i(trip),
        .low_side_source_pin_i(slp), .warn_cond_i(wc), .temperature_flags_i(tf), .supply_fault_i(sf),
        .watchdog_fault_i(wd), .regulator_undervoltage_i(uv), .gate_drive_o(gd), .strong_pd_o(spd),
        .hold_o(hold), .drain_source_threshold_o(thr), .fault_report_n_i(pin), .fault_report_n_o(fo),
        .fault_report_oe_n_o(oe_n), .power_good_out_o(pg));
    gdfm_mcu i_mcu (.clk_i(clk_i), .oe_n_i(oe_n), .dat_i(fo), .pin_o(pin), .low_len_o(low_len));
    // Free-running system clock.
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // Reports any difference between what was seen and what was expected.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic cycle; the request is held until ack is sampled at an edge.
    task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog against a hung run.
    initial begin
        tick(20000);
        error_cnt++;
        close_out();
    end
    initial begin
        void'($urandom(32'h35cb81da));
        tick(20);
        rst_i <= 0;
        tick(2);
        chk({pin, pg, gd}, {1'b1, 1'b1, 6'h00});
        k = $urandom;
        bus(1, 4'h7, k);
        bus(0, 4'h7, 0);
        chk(rd & 32'h7f, k & 32'h7f);
        bus(0, 4'hE, 0);
        chk(rd, 0);
        $display("Registers done");
        // Warning: pulse width, read stops it, recurrence repulses.
        wc <= 4'h1;
        k = 0;
        while (pin !== 1'b0 && k < 50) begin tick(1); k++; end
        while (pin === 1'b0 && k < 200) begin tick(1); k++; end
        chk(low_len, HALF);
        chk(gd, 0);
        bus(0, 4'h1, 0);
        chk(rd[7:4], 4'h1);
        tick(3);
        for (k = 0; k < 3 * HALF; k++) begin tick(1); chk(pin, 1); end
        bus(0, 4'h1, 0);
        chk(rd[7:4], 4'h1);
        wc <= 0;
        tick(3);
        wc <= 4'h1;
        tick(6);
        chk(pin, 0);
        bus(0, 4'h1, 0);
        wc <= 0;
        $display("Warning done");
        // Temperature flags are live status only.
        tf <= 4'($urandom);
        tick(3);
        bus(0, 4'h1, 0);
        chk({rd[8], rd[3:1]}, {tf[3], tf[0], tf[1], tf[2]});
        chk(pin, 1);
        tf <= 0;
        // Fault latch, clear with cause present, then proper recovery.
        sf <= 4'h2;
        tick(4);
        chk({pin, gd}, 0);
        bus(0, 4'h1, 0);
        chk(rd[10], 1);
        bus(1, 4'h9, 32'h2);
        tick(4);
        chk(pin, 0);
        sf <= 0;
        bus(1, 4'h9, 32'h2);
        tick(6);
        chk(pin, 1);
        bus(0, 4'h9, 0);
        chk(rd[1], 0);
        $display("Fault done");
        // Watchdog also drops power-good until cleared by enable pulse.
        wd <= 1;
        tick(4);
        chk({pg, pin}, 0);
        wd <= 0;
        gen <= 0;
        tick(2);
        gen <= 1;
        tick(6);
        chk({pg, pin}, 2'b11);
        $display("Power-good done");
        // Gate path: handshake, dead time, drive timer, pulldown and the three overcurrent modes.
        bus(1, 4'h7, 0);
        bus(1, 4'h9, 32'h100);
        k = $urandom;
        bus(1, 4'hC, k & 32'hf8);
        chk(thr, k[7:3]);
        fb <= 6'h01;
        gsoff <= 0;
        cmd <= 6'h01;
        tick(20);
        chk(gd, 0);
        gsoff <= 6'h3f;
        tick(11);
        chk(gd, 0);
        tick(1);
        chk(gd, 6'h01);
        tick(3);
        chk({spd[3], hold[0]}, 2'b10);
        tick(70);
        chk({spd[3], hold[0]}, 2'b01);
        trip <= 6'h01;
        tick(155);
        chk(pin, 1);
        tick(45);
        chk({pin, gd}, 0);
        bus(0, 4'h2, 0);
        chk(rd[8:0], 9'h008);
        trip <= 0;
        cmd <= 0;
        bus(1, 4'hC, 32'h1);
        bus(1, 4'h9, 32'h102);
        tick(3);
        chk(pin, 1);
        cmd <= 6'h01;
        trip <= 6'h01;
        k = 0;
        while (pin !== 1'b0 && k < 400) begin tick(1); k++; end
        chk({pin, gd}, 7'h01);
        bus(0, 4'h2, 0);
        chk(rd[8:0], 9'h008);
        bus(1, 4'hC, 32'h2);
        cmd <= 0;
        tick(2);
        cmd <= 6'h01;
        tick(300);
        chk({pin, gd}, 7'h41);
        bus(0, 4'h2, 0);
        chk(rd[8:0], 0);
        bus(1, 4'h9, 0);
        trip <= 0;
        cmd <= 0;
        tick(80);
        chk({pin, gd}, 0);
        bus(0, 4'h3, 0);
        chk(rd[11:0], 12'h010);
        slp <= 3'h4;
        uv <= 1;
        tick(4);
        chk(pg, 0);
        slp <= 0;
        uv <= 0;
        bus(0, 4'h2, 0);
        chk(rd[8:0], 9'h004);
        bus(1, 4'h9, 32'h2);
        tick(4);
        chk({pg, pin}, 2'b11);
        $display("Gates done");
        close_out();
    end
endmodule
